// ---- logic/mcc_pkg.sv ----
// Constants shared by the metering channel conditioning block.
`default_nettype none
package mcc_pkg;
  // ------------------------------------------------------------------
  // Widths and channel order
  // ------------------------------------------------------------------
  localparam int DW = 32;
  localparam int SMP_W = 24;
  localparam int NCH = 7;
  localparam int NCUR = 4;
  localparam int SEL_W = 3;
  // Datapath and modulator index: IA, IB, IC, IN, VA, VB, VC.
  localparam int CH_IA = 0;
  localparam int CH_IB = 1;
  localparam int CH_IC = 2;
  localparam int CH_IN = 3;
  localparam int CH_VA = 4;
  localparam int CH_VB = 5;
  localparam int CH_VC = 6;
  // ------------------------------------------------------------------
  // Source selector codes
  // ------------------------------------------------------------------
  localparam logic [2:0] SRC_IA = 3'h0;
  localparam logic [2:0] SRC_IC = 3'h2;
  localparam logic [2:0] SRC_VA = 3'h4;
  localparam logic [2:0] SRC_IN = 3'h7;
  // ------------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] OFS_ROUTE = 8'h00;
  localparam logic [7:0] OFS_ACC_MODE = 8'h04;
  localparam logic [7:0] OFS_CFG_FIRST = 8'h08;
  localparam logic [7:0] OFS_CFG_THIRD = 8'h0C;
  localparam logic [7:0] OFS_INT_COEFF = 8'h10;
  localparam logic [7:0] OFS_GAIN_BASE = 8'h14;
  localparam logic [7:0] OFS_PHCAL_BASE = 8'h24;
  localparam logic [7:0] OFS_COUNT = 8'h34;
  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int ACC_DERIVE_B_BIT = 0;
  localparam int CFG_HPF_DIS_BIT = 0;
  localparam int CFG_PH_INT_BIT = 1;
  localparam int CFG_N_INT_BIT = 2;
  // ------------------------------------------------------------------
  // Reset values and arithmetic scaling
  // ------------------------------------------------------------------
  localparam logic [31:0] ROUTE_RST = 32'h001A_CE88;
  localparam logic [2:0] CORNER_RST = 3'h6;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam logic [4:0] HPF_SHIFT_BASE = 5'h4;
  localparam int CAL_FRAC = 27;
  localparam int INT_FRAC = 31;
endpackage
`default_nettype wire

// ---- logic/mcc_chan.sv ----
// One conditioning channel: high-pass, integrator, gain, phase filter.
`default_nettype none
module mcc_chan #(
  parameter bit IS_VOLT = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic en,
  input wire logic hpf_dis,
  input wire logic int_en,
  input wire logic [2:0] corner,
  input wire logic [31:0] x,
  input wire logic [31:0] coeff,
  input wire logic [31:0] gain,
  input wire logic [31:0] phcal,
  output logic [31:0] y
);
  logic signed [31:0] hx_q, hy_q, int_q, g1_q, y_q;
  logic signed [31:0] hp, it, ci, g, pf;
  logic signed [63:0] ip, gp, kp, ky;
  logic [4:0] sh;

  // ------------------------------------------------------------------
  // Arithmetic
  // ------------------------------------------------------------------
  always_comb begin
    sh = {2'b00, corner} + mcc_pkg::HPF_SHIFT_BASE;
    // Leak of 2^-sh sets the corner; each code step halves it.
    hp = hpf_dis ? $signed(x) : hy_q - (hy_q >>> sh) + $signed(x) - hx_q;
    ip = int_q * $signed(coeff);
    it = int_q + hp + ip[mcc_pkg::INT_FRAC +: 32];
    ci = int_en ? it : hp;
    gp = ci * $signed(gain);
    g = ci + gp[mcc_pkg::CAL_FRAC +: 32];
    // All-pass section (k + z^-1)/(1 + k z^-1) with k = phcal / 2^27.
    kp = g * $signed(phcal);
    ky = y_q * $signed(phcal);
    pf = kp[mcc_pkg::CAL_FRAC +: 32] + g1_q - ky[mcc_pkg::CAL_FRAC +: 32];
  end

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hx_q <= '0;
      hy_q <= '0;
      int_q <= '0;
      g1_q <= '0;
      y_q <= '0;
    end else if (en) begin
      hx_q <= $signed(x);
      hy_q <= hp;
      // Clearing keeps a stale integral from bursting out on re-enable.
      int_q <= int_en ? it : 32'sh0000_0000;
      g1_q <= g;
      y_q <= IS_VOLT ? hy_q : pf;
    end
  end

  // The output shows the value that y_q takes at this step, so the output
  // register in the top adds no second sample of delay.
  assign y = IS_VOLT ? hy_q : pf;

  a_volt_delay: assert property (
    @(posedge pclk) disable iff (!presetn)
    (IS_VOLT && en) |=> (y_q == $past(hy_q)))
    else $error("voltage output is not the previous filtered sample");
endmodule
`default_nettype wire

// ---- logic/mcc_top.sv ----
// Channel conditioning datapath with routing mux and APB registers.
//
// Function
// - Each datapath picks its modulator through its own source field.
// - After reset every modulator feeds its own datapath.
// - Code 010 selects phase C current, code 000 phase A current.
// - Code 100 selects phase A voltage for any datapath.
// - Code 111 selects the neutral current for calibration.
// - The neutral path gives no zero-crossing or angle output.
// - Current gain is one plus the gain word over 2^27.
// - The gain word is signed, so gain may turn negative.
// - Derive bit makes phase B current the negated sum of A and C.
// - High-pass is on after reset; its disable bit bypasses it.
// - Corner select has codes 0 to 7 and resets to 6.
// - Corner codes set the corner, which halves per step.
// - Integrator falls 20 dB per decade with near -90 degrees.
// - One bit enables phase integrators, another the neutral one.
// - Phase filter resolves corrections of 0.001 degree.
// - Voltage paths are delayed by exactly one sample.
// - Current phase filter coefficient is phase word times 2^-27.
// - Positive correction fixes lagging current, negative leading.
// - Only the region zero phase word is applied.
//
// Our own choices: the APB slave port and the address map.
`default_nettype none
module mcc_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic smp_valid,
  input wire logic [23:0] smp_ia,
  input wire logic [23:0] smp_ib,
  input wire logic [23:0] smp_ic,
  input wire logic [23:0] smp_in,
  input wire logic [23:0] smp_va,
  input wire logic [23:0] smp_vb,
  input wire logic [23:0] smp_vc,
  output logic out_valid,
  output logic [31:0] out_ia,
  output logic [31:0] out_ib,
  output logic [31:0] out_ic,
  output logic [31:0] out_in,
  output logic [31:0] out_va,
  output logic [31:0] out_vb,
  output logic [31:0] out_vc,
  output logic [2:0] zc_cur
);
  localparam int N = mcc_pkg::NCH;

  logic [31:0] route_q, acc_q, cfg1_q, cfg3_q, coeff_q, count_q;
  logic [31:0] gain_q [mcc_pkg::NCUR];
  logic [31:0] phcal_q [mcc_pkg::NCUR];
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q;
  logic [31:0] src [8];
  logic [31:0] mux_w [N];
  logic [31:0] in_q [N];
  logic [31:0] chan_y [N];
  logic [31:0] out_q [N];
  logic [2:0] zc_q;
  logic stage1_q, out_valid_q;
  logic wr_acc, setup;
  logic [31:0] rd_d;
  logic err_d;
  logic derive_b, hpf_dis, ph_int, n_int;
  logic [2:0] corner;
  logic route_wr_seen_q, cfg_wr_seen_q;

  // ------------------------------------------------------------------
  // APB slave
  // ------------------------------------------------------------------
  // Zero-wait answer: the setup cycle loads read data and pready, so
  // every transfer completes in its first access cycle.
  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pready_q && pwrite;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r;
  endfunction

  always_comb begin
    rd_d = '0;
    err_d = 1'b0;
    unique case (paddr)
      mcc_pkg::OFS_ROUTE: rd_d = route_q;
      mcc_pkg::OFS_ACC_MODE: rd_d = acc_q;
      mcc_pkg::OFS_CFG_FIRST: rd_d = cfg1_q;
      mcc_pkg::OFS_CFG_THIRD: rd_d = cfg3_q;
      mcc_pkg::OFS_INT_COEFF: rd_d = coeff_q;
      mcc_pkg::OFS_COUNT: rd_d = count_q;
      default: begin
        err_d = 1'b1;
        for (int i = 0; i < mcc_pkg::NCUR; i++) begin
          if (paddr == mcc_pkg::OFS_GAIN_BASE + 8'(4 * i)) begin
            rd_d = gain_q[i];
            err_d = 1'b0;
          end
          if (paddr == mcc_pkg::OFS_PHCAL_BASE + 8'(4 * i)) begin
            rd_d = phcal_q[i];
            err_d = 1'b0;
          end
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= setup;
      if (setup) begin
        prdata_q <= pwrite ? 32'h0000_0000 : rd_d;
        pslverr_q <= err_d;
      end else begin
        pslverr_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      route_q <= mcc_pkg::ROUTE_RST;
      acc_q <= mcc_pkg::WORD_RST;
      cfg1_q <= mcc_pkg::WORD_RST;
      cfg3_q <= {29'h0, mcc_pkg::CORNER_RST};
      coeff_q <= mcc_pkg::WORD_RST;
    end else if (wr_acc) begin
      unique case (paddr)
        mcc_pkg::OFS_ROUTE: route_q <= merge(route_q, pwdata, pstrb) & 32'h001F_FFFF;
        mcc_pkg::OFS_ACC_MODE: acc_q <= merge(acc_q, pwdata, pstrb) & 32'h0000_0001;
        mcc_pkg::OFS_CFG_FIRST: cfg1_q <= merge(cfg1_q, pwdata, pstrb) & 32'h0000_0007;
        mcc_pkg::OFS_CFG_THIRD: cfg3_q <= merge(cfg3_q, pwdata, pstrb) & 32'h0000_0007;
        mcc_pkg::OFS_INT_COEFF: coeff_q <= merge(coeff_q, pwdata, pstrb);
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < mcc_pkg::NCUR; i++) begin
        gain_q[i] <= mcc_pkg::WORD_RST;
        phcal_q[i] <= mcc_pkg::WORD_RST;
      end
    end else if (wr_acc) begin
      for (int i = 0; i < mcc_pkg::NCUR; i++) begin
        if (paddr == mcc_pkg::OFS_GAIN_BASE + 8'(4 * i)) begin
          gain_q[i] <= merge(gain_q[i], pwdata, pstrb);
        end
        if (paddr == mcc_pkg::OFS_PHCAL_BASE + 8'(4 * i)) begin
          phcal_q[i] <= merge(phcal_q[i], pwdata, pstrb);
        end
      end
    end
  end

  assign derive_b = acc_q[mcc_pkg::ACC_DERIVE_B_BIT];
  assign hpf_dis = cfg1_q[mcc_pkg::CFG_HPF_DIS_BIT];
  assign ph_int = cfg1_q[mcc_pkg::CFG_PH_INT_BIT];
  assign n_int = cfg1_q[mcc_pkg::CFG_N_INT_BIT];
  assign corner = cfg3_q[2:0];

  // ------------------------------------------------------------------
  // Routing multiplexer
  // ------------------------------------------------------------------
  always_comb begin
    src[0] = 32'(signed'(smp_ia));
    src[1] = 32'(signed'(smp_ib));
    src[2] = 32'(signed'(smp_ic));
    src[3] = 32'(signed'(smp_in));
    src[4] = 32'(signed'(smp_va));
    src[5] = 32'(signed'(smp_vb));
    src[6] = 32'(signed'(smp_vc));
    src[7] = 32'(signed'(smp_in));
  end

  for (genvar c = 0; c < N; c++) begin : g_mux
    assign mux_w[c] = src[route_q[3*c +: 3]];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < N; c++) begin
        in_q[c] <= '0;
      end
      stage1_q <= 1'b0;
      count_q <= '0;
    end else begin
      stage1_q <= smp_valid;
      if (smp_valid) begin
        for (int c = 0; c < N; c++) begin
          in_q[c] <= mux_w[c];
        end
        if (derive_b) begin
          in_q[mcc_pkg::CH_IB] <= -(mux_w[mcc_pkg::CH_IA] + mux_w[mcc_pkg::CH_IC]);
        end
        count_q <= count_q + 32'h0000_0001;
      end
    end
  end

  // ------------------------------------------------------------------
  // Channel filters
  // ------------------------------------------------------------------
  for (genvar c = 0; c < N; c++) begin : g_chan
    localparam bit VOLT = (c >= mcc_pkg::NCUR);
    localparam int K = VOLT ? 0 : c;
    mcc_chan #(.IS_VOLT(VOLT)) u_chan (
      .pclk(pclk),
      .presetn(presetn),
      .en(stage1_q),
      .hpf_dis(hpf_dis),
      .int_en(VOLT ? 1'b0 : (c == mcc_pkg::CH_IN ? n_int : ph_int)),
      .corner(corner),
      .x(in_q[c]),
      .coeff(coeff_q),
      .gain(VOLT ? mcc_pkg::WORD_RST : gain_q[K]),
      .phcal(VOLT ? mcc_pkg::WORD_RST : phcal_q[K]),
      .y(chan_y[c])
    );
  end

  // ------------------------------------------------------------------
  // Outputs and phase current zero crossings
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < N; c++) begin
        out_q[c] <= '0;
      end
      out_valid_q <= 1'b0;
      zc_q <= '0;
    end else begin
      out_valid_q <= stage1_q;
      zc_q <= '0;
      if (stage1_q) begin
        for (int c = 0; c < N; c++) begin
          out_q[c] <= chan_y[c];
        end
        // Only the three phase currents; the neutral has none.
        for (int c = 0; c < 3; c++) begin
          zc_q[c] <= out_q[c][31] != chan_y[c][31];
        end
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign out_valid = out_valid_q;
  assign out_ia = out_q[0];
  assign out_ib = out_q[1];
  assign out_ic = out_q[2];
  assign out_in = out_q[3];
  assign out_va = out_q[4];
  assign out_vb = out_q[5];
  assign out_vc = out_q[6];
  assign zc_cur = zc_q;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      route_wr_seen_q <= 1'b0;
      cfg_wr_seen_q <= 1'b0;
    end else if (wr_acc) begin
      if (paddr == mcc_pkg::OFS_ROUTE) begin
        route_wr_seen_q <= 1'b1;
      end
      if (paddr == mcc_pkg::OFS_CFG_FIRST || paddr == mcc_pkg::OFS_CFG_THIRD) begin
        cfg_wr_seen_q <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_route_any: assert property (
    (smp_valid && !derive_b) |=> in_q[1] == $past(src[route_q[5:3]]))
    else $error("datapath B did not take its selected source");
  a_route_default: assert property (
    !route_wr_seen_q |-> route_q == mcc_pkg::ROUTE_RST)
    else $error("routing map left its reset mapping unwritten");
  a_swap_ac: assert property (
    (smp_valid && route_q[2:0] == mcc_pkg::SRC_IC) |=> in_q[0] == $past(src[2]))
    else $error("code 010 did not route phase C current");
  a_va_fanout: assert property (
    (smp_valid && route_q[17:15] == mcc_pkg::SRC_VA) |=> in_q[5] == $past(src[4]))
    else $error("code 100 did not route phase A voltage");
  a_neutral_in: assert property (
    (smp_valid && !derive_b && route_q[5:3] == mcc_pkg::SRC_IN) |=>
      in_q[1] == $past(src[3]))
    else $error("code 111 did not route neutral current");
  a_derive_b: assert property (
    (smp_valid && derive_b) |=>
      in_q[1] == -($past(mux_w[0]) + $past(mux_w[2])))
    else $error("phase B current is not minus A minus C");
  a_hpf_default: assert property (
    !cfg_wr_seen_q |-> (!hpf_dis && corner == mcc_pkg::CORNER_RST))
    else $error("high-pass not active at corner 6 after reset");
  a_sample_flow: assert property (
    smp_valid |=> stage1_q ##1 (out_valid_q && out_q[4] == $past(chan_y[4])))
    else $error("sample did not reach the outputs two cycles later");
  a_apb_answer: assert property (
    (setup && !pwrite && paddr == mcc_pkg::OFS_INT_COEFF) |=>
      (pready_q && prdata_q == coeff_q))
    else $error("coefficient read answered wrongly");

  c_derive: cover property (smp_valid && derive_b);
  c_swap: cover property (smp_valid && route_q[2:0] == mcc_pkg::SRC_IC);
  c_integrate: cover property (stage1_q && ph_int && !hpf_dis);
  c_zero_cross: cover property (zc_q != 3'h0);
endmodule
`default_nettype wire

// ---- tb/mcc_mod_model.sv ----
// Behavioural stand-in for the seven converter outputs feeding the block.
`default_nettype none
module mcc_mod_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic fire,
  input wire logic [167:0] vals,
  output logic smp_valid,
  output logic [167:0] smp
);
  timeunit 1ns;
  timeprecision 1ps;
  // Outside the strobe the lines carry the inverse of the set, so a block
  // that reads samples without the strobe sees wrong data, not stale data.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      smp_valid <= 1'b0;
      smp <= '0;
    end else begin
      smp_valid <= fire;
      smp <= fire ? vals : ~vals;
    end
  end
endmodule
`default_nettype wire

// ---- tb/test_metering_channel_conditioning.sv ----
// Self-checking bench for the channel conditioning block.
`default_nettype none
module test_metering_channel_conditioning;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [167:0] BASE = {24'h00_7700, 24'h00_6600, 24'h00_5500,
    24'h00_4400, 24'h00_3300, 24'h00_2200, 24'h00_1100};
  localparam logic [167:0] NEG = {24'h00_7700, 24'h00_6600, 24'h00_5500,
    24'hFF_C000, 24'h00_3300, 24'h00_2200, 24'hFF_F000};
  localparam logic [167:0] ALT = {7{24'h00_0123}};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic fire = 1'b0;
  logic [167:0] vals = '0;
  logic [167:0] smp;
  logic [31:0] prdata;
  logic [31:0] outs [7];
  logic [2:0] zc_cur;
  logic [2:0] zc_or;
  logic pready, pslverr, smp_valid, out_valid, err;
  logic [31:0] rd;
  int zc_a;
  int fails = 0;
  int checks_done = 0;
  int srcs [7];

  always #2 pclk = ~pclk;

  mcc_mod_model src (.pclk(pclk), .presetn(presetn), .fire(fire),
    .vals(vals), .smp_valid(smp_valid), .smp(smp));

  mcc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .smp_valid(smp_valid), .smp_ia(smp[23:0]), .smp_ib(smp[47:24]),
    .smp_ic(smp[71:48]), .smp_in(smp[95:72]), .smp_va(smp[119:96]),
    .smp_vb(smp[143:120]), .smp_vc(smp[167:144]), .out_valid(out_valid),
    .out_ia(outs[0]), .out_ib(outs[1]), .out_ic(outs[2]), .out_in(outs[3]),
    .out_va(outs[4]), .out_vb(outs[5]), .out_vc(outs[6]), .zc_cur(zc_cur));

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic [31:0] ch(input logic [167:0] v, input int c);
    return {{8{v[24*c+23]}}, v[24*c +: 24]};
  endfunction

  function automatic logic [31:0] rmap(input logic [2:0] c0, c1, c2, c3,
      c4, c5, c6);
    return {11'h000, c6, c5, c4, c3, c2, c1, c0};
  endfunction

  function automatic logic [31:0] gained(input logic [31:0] x, g);
    longint xs;
    longint gs;
    xs = longint'($signed(x));
    gs = longint'($signed(g));
    return 32'(xs + ((xs * gs) >>> 27));
  endfunction

  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic stuck(input string what);
    fails++;
    $display("unexpected %s: expected 1, seen 0", what);
    wrap_up();
  endtask

  // Requests change just after a rising edge and are released only after
  // the edge at which pready was seen high.
  task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) stuck("pready");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input string w, input logic [7:0] a,
      input logic [31:0] exp, input logic experr);
    apb(1'b0, a, 32'h0000_0000);
    chk(w, exp, rd);
    chk("slave error", 32'(experr), 32'(err));
  endtask

  task automatic run(input logic [167:0] v, input int reps);
    int n;
    for (int r = 0; r < reps; r++) begin
      @(posedge pclk);
      vals <= v;
      fire <= 1'b1;
      @(posedge pclk);
      fire <= 1'b0;
      n = 0;
      do begin
        @(negedge pclk);
        n++;
      end while (out_valid !== 1'b1 && n < 8);
      if (n >= 8) stuck("out_valid");
      zc_a += 32'(zc_cur[0]);
      zc_or |= zc_cur;
    end
  endtask

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rchk("route", 8'h00, rmap(0, 1, 2, 7, 4, 5, 6), 1'b0);
    rchk("accumulation mode", 8'h04, 32'h0000_0000, 1'b0);
    rchk("cfg first", 8'h08, 32'h0000_0000, 1'b0);
    rchk("cfg third", 8'h0C, 32'h0000_0006, 1'b0);
    rchk("coeff", 8'h10, 32'h0000_0000, 1'b0);
    rchk("unmapped", 8'h38, 32'h0000_0000, 1'b1);
    for (int k = 0; k < 8; k++) begin
      apb(1'b1, 8'h0C, 32'(k));
      rchk("corner", 8'h0C, 32'(k), 1'b0);
    end
    apb(1'b1, 8'h0C, 32'hFFFF_FFF8);
    rchk("corner field", 8'h0C, 32'h0000_0000, 1'b0);
    $display("test registers done");
    run(BASE, 4);
    chk("hpf decay", 32'h0000_0001, 32'($signed(outs[0]) < $signed(ch(BASE, 0))));
    apb(1'b1, 8'h08, 32'h0000_0001);
    run(BASE, 3);
    for (int c = 0; c < 7; c++) chk("own path", ch(BASE, c), outs[c]);
    $display("test high-pass done");
    apb(1'b1, 8'h00, rmap(2, 7, 0, 7, 4, 4, 4));
    run(BASE, 2);
    srcs = '{2, 3, 0, 3, 4, 4, 4};
    for (int c = 0; c < 7; c++) chk("routed", ch(BASE, srcs[c]), outs[c]);
    apb(1'b1, 8'h00, rmap(0, 1, 2, 7, 4, 5, 6));
    run(BASE, 2);
    run(ALT, 1);
    chk("voltage delay", ch(BASE, 4), outs[4]);
    run(ALT, 1);
    chk("voltage next", ch(ALT, 4), outs[4]);
    $display("test routing done");
    // Gains of -1 and 1.1 keep every phase well inside the 3.75 product.
    apb(1'b1, 8'h14, 32'hF000_0000);
    apb(1'b1, 8'h1C, 32'h00CC_CCCD);
    run(BASE, 3);
    chk("gain minus one", -ch(BASE, 0), outs[0]);
    chk("gain up", gained(ch(BASE, 2), 32'h00CC_CCCD), outs[2]);
    apb(1'b1, 8'h14, 32'h0000_0000);
    apb(1'b1, 8'h1C, 32'h0000_0000);
    apb(1'b1, 8'h04, 32'h0000_0001);
    run(BASE, 3);
    chk("derived b", -(ch(BASE, 0) + ch(BASE, 2)), outs[1]);
    apb(1'b1, 8'h04, 32'h0000_0000);
    $display("test gain done");
    run(BASE, 2);
    zc_a = 0;
    zc_or = 3'h0;
    run(NEG, 2);
    chk("zero cross a", 32'h0000_0001, 32'(zc_a));
    chk("zero cross bc", 32'h0000_0000, 32'(zc_or[2:1]));
    chk("negative a", ch(NEG, 0), outs[0]);
    $display("test zero crossing done");
    apb(1'b1, 8'h10, 32'hFFFF_E000);
    apb(1'b1, 8'h08, 32'h0000_0003);
    run(BASE, 3);
    chk("phase integ", 32'h0000_0001, 32'($signed(outs[0]) > $signed(ch(BASE, 0))));
    chk("neutral plain", ch(BASE, 3), outs[3]);
    apb(1'b1, 8'h08, 32'h0000_0005);
    run(BASE, 3);
    chk("neutral integ", 32'h0000_0001, 32'($signed(outs[3]) > $signed(ch(BASE, 3))));
    chk("phase plain", ch(BASE, 0), outs[0]);
    $display("test integrator done");
    apb(1'b1, 8'h24, 32'h0400_0000);
    run(ALT, 1);
    // A half coefficient on a step from 0x1100 to 0x123 gives the new
    // sample times k, plus the old input, minus the old output times k.
    chk("phase filter", 32'h0000_0911, outs[0]);
    $display("test phase filter done");
    wrap_up();
  end
endmodule
`default_nettype wire
